// ### core/modem_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// two-port byte store, read data registered on both ports
module modem_buffer
    import modem_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = $clog2(DEPTH)
)
(
    input wire logic clk_sys,
    input wire logic [AW-1:0] a_waddr,
    input wire logic [AW-1:0] a_raddr,
    input wire logic a_we,
    input wire logic [WIDTH-1:0] a_wdata,
    output logic [WIDTH-1:0] a_q,
    input wire logic [AW-1:0] b_addr,
    input wire logic b_we,
    input wire logic [WIDTH-1:0] b_wdata,
    output logic [WIDTH-1:0] b_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    // if both write ports hit one byte in the same cycle, the port b write wins
    always_ff @(posedge clk_sys)
    begin
        if (a_we)
            mem[a_waddr] <= a_wdata;
        if (b_we)
            mem[b_addr] <= b_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        a_q <= mem[a_raddr];
        b_q <= mem[b_addr];
    end

endmodule // modem_buffer

`default_nettype wire

// ### core/modem_pkg.sv
package modem_pkg;

    localparam int ADDR_W = 7;
    localparam int BUF_DEPTH = 256;

    // register offsets
    localparam logic [6:0] ADR_DATA_PORT = 7'h00;
    localparam logic [6:0] ADR_OP_MODE = 7'h01;
    localparam logic [6:0] ADR_CARRIER_MSB = 7'h06;
    localparam logic [6:0] ADR_CARRIER_MID = 7'h07;
    localparam logic [6:0] ADR_CARRIER_LSB = 7'h08;
    localparam logic [6:0] ADR_ACCESS_PTR = 7'h0D;
    localparam logic [6:0] ADR_TX_BASE = 7'h0E;
    localparam logic [6:0] ADR_RX_BASE = 7'h0F;
    localparam logic [6:0] ADR_IRQ_FLAGS = 7'h12;
    localparam logic [6:0] ADR_RX_COUNT = 7'h13;
    localparam logic [6:0] ADR_RX_WPTR = 7'h14;
    localparam logic [6:0] ADR_TIMEOUT_SYM = 7'h1F;
    localparam logic [6:0] ADR_PAYLOAD_LEN = 7'h22;
    localparam logic [6:0] ADR_IF_MSB = 7'h2F;
    localparam logic [6:0] ADR_IF_LSB = 7'h30;
    localparam logic [6:0] ADR_GUARD = 7'h31;

    // operating mode register fields
    localparam int LRE_BIT = 7;
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_SYNTH_TX = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_SYNTH_RX = 3'h4;
    localparam logic [2:0] MODE_RX_CONT = 3'h5;
    localparam logic [2:0] MODE_RX_SINGLE = 3'h6;

    // interrupt flag positions
    localparam int FLG_TIMEOUT = 7;
    localparam int FLG_RX_DONE = 6;
    localparam int FLG_CHECK_ERR = 5;
    localparam int FLG_HDR_VALID = 4;
    localparam int FLG_TX_DONE = 3;

    // reset values
    localparam logic [23:0] CARRIER_RST = 24'h6C8000;
    localparam logic [15:0] IF_RST = 16'h0560;
    localparam logic [7:0] TX_BASE_RST = 8'h80;
    localparam logic [7:0] RX_BASE_RST = 8'h00;
    localparam logic [7:0] PAYLOAD_RST = 8'h01;
    localparam logic [7:0] TIMEOUT_SYM_RST = 8'h64;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int PA_RAMP_NS = 40000;
    localparam int PA_RAMP_CYCLES = (PA_RAMP_NS * CLK_MHZ + 999) / 1000;
    localparam int SYMBOL_US = 1024;
    localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_STANDBY,
        ST_SYNTH_TX,
        ST_TX,
        ST_SYNTH_RX,
        ST_RX_CONT,
        ST_RX_SINGLE
    } seq_state_t;

endpackage

// ### core/modem_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module modem_sequencer
    import modem_pkg::*;
#(
    parameter int SYM_CYCLES = SYMBOL_CYCLES,
    parameter int RAMP_CYCLES = PA_RAMP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic link_clk,
    input wire logic [7:0] demod_byte,
    input wire logic demod_byte_valid,
    input wire logic demod_preamble,
    input wire logic demod_header,
    input wire logic demod_end,
    input wire logic demod_crc_bad,
    output logic xosc_on,
    output logic baseband_on,
    output logic synth_on,
    output logic synth_rx_sel,
    output logic [23:0] carrier_word,
    output logic [15:0] if_word,
    output logic tx_chain_on,
    output logic pa_ramp,
    output logic rx_chain_on,
    output logic gain_hold,
    output logic [7:0] mod_byte,
    output logic mod_byte_valid
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, link clock edge

    localparam int SW = 14;
    logic [SW-1:0] pin_s1_r, pin_s2_r;
    logic link_prev_r;
    logic link_rise;
    logic [7:0] dbyte_s;
    logic dvalid_s, dpre_s, dhdr_s, dend_s, dcrc_s;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            link_prev_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {link_clk, demod_byte, demod_byte_valid,
                demod_preamble, demod_header, demod_end, demod_crc_bad};
            pin_s2_r <= pin_s1_r;
            link_prev_r <= pin_s2_r[SW-1];
        end
    end

    assign link_rise = pin_s2_r[SW-1] && !link_prev_r;
    assign dbyte_s = pin_s2_r[12:5];
    assign dvalid_s = pin_s2_r[4];
    assign dpre_s = pin_s2_r[3];
    assign dhdr_s = pin_s2_r[2];
    assign dend_s = pin_s2_r[1];
    assign dcrc_s = pin_s2_r[0];

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic lre_r, guard_r;
    logic [23:0] carrier_r;
    logic [15:0] if_r;
    logic [7:0] tx_base_r, rx_base_r, payload_r, tmo_sym_r;
    seq_state_t state_r, state_nxt;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            lre_r <= 1'b0;
            guard_r <= 1'b0;
            carrier_r <= CARRIER_RST;
            if_r <= IF_RST;
            tx_base_r <= TX_BASE_RST;
            rx_base_r <= RX_BASE_RST;
            payload_r <= PAYLOAD_RST;
            tmo_sym_r <= TIMEOUT_SYM_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADR_OP_MODE && state_r == ST_SLEEP)
                lre_r <= reg_wdata[LRE_BIT];
            else if (reg_addr == ADR_CARRIER_MSB)
                carrier_r[23:16] <= reg_wdata;
            else if (reg_addr == ADR_CARRIER_MID)
                carrier_r[15:8] <= reg_wdata;
            else if (reg_addr == ADR_CARRIER_LSB)
                carrier_r[7:0] <= reg_wdata;
            else if (reg_addr == ADR_IF_MSB)
                if_r[15:8] <= reg_wdata;
            else if (reg_addr == ADR_IF_LSB)
                if_r[7:0] <= reg_wdata;
            else if (reg_addr == ADR_TX_BASE)
                tx_base_r <= reg_wdata;
            else if (reg_addr == ADR_RX_BASE)
                rx_base_r <= reg_wdata;
            else if (reg_addr == ADR_PAYLOAD_LEN)
                payload_r <= reg_wdata;
            else if (reg_addr == ADR_TIMEOUT_SYM)
                tmo_sym_r <= reg_wdata;
            else if (reg_addr == ADR_GUARD)
                guard_r <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer

    logic mode_wr, lre_eff, rx_start, tx_start;
    logic tx_finish, pkt_end, timeout_hit;
    seq_state_t req_state;

    // a new lre value written in sleep takes effect with the same write
    assign mode_wr = reg_wr && reg_addr == ADR_OP_MODE;
    assign lre_eff = state_r == ST_SLEEP ? reg_wdata[LRE_BIT] : lre_r;

    always_comb
    begin
        req_state = state_r;
        case (reg_wdata[2:0])
            MODE_SLEEP: req_state = ST_SLEEP;
            MODE_STANDBY: req_state = ST_STANDBY;
            MODE_SYNTH_TX: req_state = ST_SYNTH_TX;
            MODE_TX: req_state = ST_TX;
            MODE_SYNTH_RX: req_state = ST_SYNTH_RX;
            MODE_RX_CONT: req_state = ST_RX_CONT;
            MODE_RX_SINGLE: req_state = ST_RX_SINGLE;
            default: req_state = state_r;
        endcase
        // without the long-range bit only sleep and standby are served
        if (!lre_eff && req_state != ST_SLEEP && req_state != ST_STANDBY)
            req_state = state_r;
    end

    // a host request in the same cycle as an automatic return wins
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_TX:
                if (tx_finish)
                    state_nxt = ST_STANDBY;
            ST_RX_SINGLE:
                if (pkt_end || timeout_hit)
                    state_nxt = ST_STANDBY;
            ST_RX_CONT:
                if (timeout_hit)
                    state_nxt = ST_STANDBY;
            default:
                state_nxt = state_r;
        endcase
        if (mode_wr)
            state_nxt = req_state;
    end

    assign rx_start = mode_wr && req_state != state_r &&
        (req_state == ST_RX_CONT || req_state == ST_RX_SINGLE);
    assign tx_start = mode_wr && req_state == ST_TX && state_r != ST_TX;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_SLEEP;
        else
            state_r <= state_nxt;
    end

    logic in_rx;
    assign in_rx = state_r == ST_RX_CONT || state_r == ST_RX_SINGLE;

    // analog enables and frequency words
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            xosc_on <= 1'b0;
            baseband_on <= 1'b0;
            synth_on <= 1'b0;
            synth_rx_sel <= 1'b0;
            rx_chain_on <= 1'b0;
            tx_chain_on <= 1'b0;
            carrier_word <= CARRIER_RST;
            if_word <= '0;
        end
        else
        begin
            xosc_on <= state_nxt != ST_SLEEP;
            baseband_on <= state_nxt != ST_SLEEP;
            synth_on <= state_nxt != ST_SLEEP && state_nxt != ST_STANDBY;
            synth_rx_sel <= state_nxt == ST_SYNTH_RX ||
                state_nxt == ST_RX_CONT || state_nxt == ST_RX_SINGLE;
            rx_chain_on <= state_nxt == ST_RX_CONT ||
                state_nxt == ST_RX_SINGLE;
            tx_chain_on <= state_nxt == ST_TX;
            carrier_word <= carrier_r;
            if_word <= (state_nxt == ST_RX_CONT ||
                state_nxt == ST_RX_SINGLE) ? if_r : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer access from the register port

    logic data_acc;
    logic [7:0] ptr_r, ptr_nxt, q_a, q_b;

    // sleep refuses the data port: no store, no pointer move, reads zero
    assign data_acc = (reg_wr || reg_rd) && reg_addr == ADR_DATA_PORT &&
        state_r != ST_SLEEP;

    always_comb
    begin
        ptr_nxt = ptr_r;
        if (data_acc)
            ptr_nxt = ptr_r + 8'h01;
        else if (reg_wr && reg_addr == ADR_ACCESS_PTR)
            ptr_nxt = reg_wdata;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ptr_r <= 8'h00;
        else
            ptr_r <= ptr_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit engine

    logic [7:0] tx_ptr_r, tx_left_r, wipe_r, rx_wptr_r;
    logic [$clog2(RAMP_CYCLES+1)-1:0] ramp_r;
    logic b_we;
    logic [7:0] b_addr, b_wdata;
    logic rx_wr;

    assign tx_finish = state_r == ST_TX && ramp_r == '0 && link_rise &&
        tx_left_r == 8'h00;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_ptr_r <= 8'h00;
            tx_left_r <= 8'h00;
            ramp_r <= '0;
            mod_byte <= 8'h00;
            mod_byte_valid <= 1'b0;
            pa_ramp <= 1'b0;
        end
        else if (tx_start)
        begin
            tx_ptr_r <= tx_base_r;
            tx_left_r <= payload_r;
            ramp_r <= RAMP_CYCLES[$bits(ramp_r)-1:0];
            pa_ramp <= 1'b1;
            mod_byte_valid <= 1'b0;
        end
        else if (state_r != ST_TX || state_nxt != ST_TX)
        begin
            // a host abort drops the ramp and the stream with the chain
            pa_ramp <= 1'b0;
            mod_byte_valid <= 1'b0;
        end
        else if (ramp_r != '0)
        begin
            ramp_r <= ramp_r - 1'b1;
            pa_ramp <= ramp_r != 1;
        end
        else if (link_rise)
        begin
            // one byte per link clock period, read ahead from the buffer
            mod_byte_valid <= tx_left_r != 8'h00;
            if (tx_left_r != 8'h00)
            begin
                mod_byte <= q_b;
                tx_ptr_r <= tx_ptr_r + 8'h01;
                tx_left_r <= tx_left_r - 8'h01;
            end
        end
    end

    // sleep wipes the store one byte a cycle; nothing can read it meanwhile
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            wipe_r <= 8'h00;
        else if (state_r == ST_SLEEP)
            wipe_r <= wipe_r + 8'h01;
        else
            wipe_r <= 8'h00;
    end

    assign b_we = state_r == ST_SLEEP || rx_wr;
    assign b_addr = state_r == ST_SLEEP ? wipe_r :
        (in_rx ? rx_wptr_r : tx_ptr_r);
    assign b_wdata = state_r == ST_SLEEP ? 8'h00 : dbyte_s;

    modem_buffer #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .clk_sys(clk_sys),
        .a_waddr(ptr_r),
        .a_raddr(ptr_nxt),
        .a_we(data_acc && reg_wr),
        .a_wdata(reg_wdata),
        .a_q(q_a),
        .b_addr(b_addr),
        .b_we(b_we),
        .b_wdata(b_wdata),
        .b_q(q_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // receive engine

    logic [7:0] live_cnt_r, rx_count_r, sym_cnt_r;
    logic got_pkt_r, hdr_seen, pre_seen, byte_seen;
    logic [$clog2(SYM_CYCLES)-1:0] sym_div_r;
    logic sym_tick;

    assign pre_seen = in_rx && link_rise && dpre_s && !gain_hold;
    assign hdr_seen = in_rx && link_rise && dhdr_s && gain_hold;
    assign byte_seen = in_rx && link_rise && dvalid_s && gain_hold;
    assign pkt_end = in_rx && link_rise && dend_s && gain_hold;
    assign rx_wr = byte_seen &&
        !(guard_r && rx_wptr_r == tx_base_r);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            gain_hold <= 1'b0;
            rx_wptr_r <= 8'h00;
            live_cnt_r <= 8'h00;
            rx_count_r <= 8'h00;
            got_pkt_r <= 1'b0;
        end
        else if (rx_start)
        begin
            // byte count and packet status from an earlier receive are dropped here; the interrupt flags are kept
            gain_hold <= 1'b0;
            rx_wptr_r <= rx_base_r;
            live_cnt_r <= 8'h00;
            rx_count_r <= 8'h00;
            got_pkt_r <= 1'b0;
        end
        else if (!in_rx)
            gain_hold <= 1'b0;
        else
        begin
            if (pre_seen)
                gain_hold <= 1'b1;
            if (rx_wr)
            begin
                rx_wptr_r <= rx_wptr_r + 8'h01;
                live_cnt_r <= live_cnt_r + 8'h01;
            end
            if (pkt_end)
            begin
                // only the latest packet's byte count is kept; re-arm for the next one
                rx_count_r <= live_cnt_r;
                live_cnt_r <= 8'h00;
                gain_hold <= 1'b0;
                got_pkt_r <= 1'b1;
            end
            // leaving receive drops the gain together with the chain
            if (state_nxt != ST_RX_CONT && state_nxt != ST_RX_SINGLE)
                gain_hold <= 1'b0;
        end
    end

    // absolute timer, started on receive entry; zero symbols disables it
    assign sym_tick = sym_div_r == '0;
    assign timeout_hit = in_rx && !got_pkt_r && tmo_sym_r != 8'h00 &&
        sym_cnt_r == tmo_sym_r;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sym_div_r <= '0;
            sym_cnt_r <= 8'h00;
        end
        else if (rx_start || !in_rx)
        begin
            sym_div_r <= $bits(sym_div_r)'(SYM_CYCLES - 1);
            sym_cnt_r <= 8'h00;
        end
        else if (sym_tick)
        begin
            sym_div_r <= $bits(sym_div_r)'(SYM_CYCLES - 1);
            if (sym_cnt_r != 8'hFF)
                sym_cnt_r <= sym_cnt_r + 8'h01;
        end
        else
            sym_div_r <= sym_div_r - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags: write one to clear, a new event wins over the clear

    logic [7:0] flags_r, flag_set, flag_clr;

    always_comb
    begin
        flag_set = 8'h00;
        flag_set[FLG_TIMEOUT] = timeout_hit;
        flag_set[FLG_RX_DONE] = pkt_end;
        flag_set[FLG_CHECK_ERR] = pkt_end && dcrc_s;
        flag_set[FLG_HDR_VALID] = hdr_seen;
        flag_set[FLG_TX_DONE] = tx_finish;
        flag_clr = (reg_wr && reg_addr == ADR_IRQ_FLAGS) ? reg_wdata : 8'h00;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            flags_r <= 8'h00;
        else
            flags_r <= (flags_r & ~flag_clr) | flag_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid in the cycle after the strobe

    logic [2:0] mode_code;

    always_comb
    begin
        case (state_r)
            ST_STANDBY: mode_code = MODE_STANDBY;
            ST_SYNTH_TX: mode_code = MODE_SYNTH_TX;
            ST_TX: mode_code = MODE_TX;
            ST_SYNTH_RX: mode_code = MODE_SYNTH_RX;
            ST_RX_CONT: mode_code = MODE_RX_CONT;
            ST_RX_SINGLE: mode_code = MODE_RX_SINGLE;
            default: mode_code = MODE_SLEEP;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == ADR_DATA_PORT)
                reg_rdata <= data_acc ? q_a : 8'h00;
            else if (reg_addr == ADR_OP_MODE)
                reg_rdata <= {lre_r, 4'h0, mode_code};
            else if (reg_addr == ADR_CARRIER_MSB)
                reg_rdata <= carrier_r[23:16];
            else if (reg_addr == ADR_CARRIER_MID)
                reg_rdata <= carrier_r[15:8];
            else if (reg_addr == ADR_CARRIER_LSB)
                reg_rdata <= carrier_r[7:0];
            else if (reg_addr == ADR_ACCESS_PTR)
                reg_rdata <= ptr_r;
            else if (reg_addr == ADR_TX_BASE)
                reg_rdata <= tx_base_r;
            else if (reg_addr == ADR_RX_BASE)
                reg_rdata <= rx_base_r;
            else if (reg_addr == ADR_IRQ_FLAGS)
                reg_rdata <= flags_r;
            else if (reg_addr == ADR_RX_COUNT)
                reg_rdata <= rx_count_r;
            else if (reg_addr == ADR_RX_WPTR)
                reg_rdata <= rx_wptr_r;
            else if (reg_addr == ADR_TIMEOUT_SYM)
                reg_rdata <= tmo_sym_r;
            else if (reg_addr == ADR_PAYLOAD_LEN)
                reg_rdata <= payload_r;
            else if (reg_addr == ADR_IF_MSB)
                reg_rdata <= if_r[15:8];
            else if (reg_addr == ADR_IF_LSB)
                reg_rdata <= if_r[7:0];
            else if (reg_addr == ADR_GUARD)
                reg_rdata <= {7'h00, guard_r};
            else
                reg_rdata <= 8'h00;
        end
    end

endmodule // modem_sequencer

`default_nettype wire

// ### tb/demod_model.sv
`timescale 1ns/1ps
`default_nettype none
// link side: clock runs only while run is high, one packet per send
module demod_model(
    input wire logic run,
    input wire logic send,
    input wire logic bad,
    output logic link_clk,
    output logic [7:0] demod_byte,
    output logic demod_byte_valid,
    output logic demod_preamble,
    output logic demod_header,
    output logic demod_end,
    output logic demod_crc_bad
);
int k = 0;
initial link_clk = 1'b0;
always #80 link_clk = run ? ~link_clk : 1'b0;
// levels change on the falling edge, away from the sampling edge
always @(negedge link_clk or negedge send)
begin
    if (!send)
        k <= 0;
    else
        k <= k + 1;
end
assign demod_preamble = k == 1;
assign demod_header = k == 2;
assign demod_byte_valid = k > 2 && k < 6;
// idle data line toggles so a stale byte never looks valid
assign demod_byte = demod_byte_valid ? 8'hA0 + k[7:0] : ~(8'hA0 + k[7:0]);
assign demod_end = k == 6;
assign demod_crc_bad = bad && k == 6;
endmodule // demod_model
`default_nettype wire

// ### tb/modem_chk.sv
`timescale 1ns/1ps
`default_nettype none
module modem_chk(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic xosc_on,
    input wire logic baseband_on,
    input wire logic synth_on,
    input wire logic synth_rx_sel,
    input wire logic [15:0] if_word,
    input wire logic tx_chain_on,
    input wire logic pa_ramp,
    input wire logic rx_chain_on,
    input wire logic gain_hold,
    input wire logic mod_byte_valid
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////
a_osc_base: assert property (xosc_on == baseband_on)
    else $error("oscillator and baseband differ");
a_tx_freq: assert property (tx_chain_on |-> synth_on && !synth_rx_sel)
    else $error("transmit without tx synthesis");
a_rx_freq: assert property (rx_chain_on |-> synth_on && synth_rx_sel)
    else $error("receive without rx synthesis");
a_if_rx: assert property (!synth_rx_sel |-> if_word == 16'h0000)
    else $error("intermediate word outside receive");
a_ramp_start: assert property ($rose(tx_chain_on) |-> pa_ramp)
    else $error("transmit without ramp");
a_ramp_end: assert property ($rose(pa_ramp) |-> ##[1:8] !pa_ramp)
    else $error("ramp does not finish");
a_ramp_quiet: assert property (pa_ramp |-> !mod_byte_valid)
    else $error("byte sent during ramp");
a_tx_stream: assert property (mod_byte_valid |-> tx_chain_on)
    else $error("byte sent outside transmit");
a_gain_rx: assert property (gain_hold |-> rx_chain_on)
    else $error("gain held outside receive");
a_rd_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
// one cycle of margin so a mode change in flight cannot trip it
a_sleep_void: assert property (reg_rd && reg_addr == 7'h00 && !xosc_on &&
    !$past(xosc_on) |=> reg_rdata == 8'h00)
    else $error("buffer readable in sleep");
endmodule // modem_chk
bind modem_sequencer modem_chk u_chk(.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xosc_on(xosc_on), .baseband_on(baseband_on), .synth_on(synth_on),
    .synth_rx_sel(synth_rx_sel), .if_word(if_word),
    .tx_chain_on(tx_chain_on), .pa_ramp(pa_ramp),
    .rx_chain_on(rx_chain_on), .gain_hold(gain_hold),
    .mod_byte_valid(mod_byte_valid));
`default_nettype wire

// ### tb/radio_modem_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, a, e); end end
module radio_modem_mode_sequencer_tb_top;
logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
logic run = 0, send = 0, bad = 0;
logic [6:0] reg_addr = 0;
logic [7:0] reg_wdata = 0, reg_rdata, mod_byte, demod_byte, v;
logic xosc_on, baseband_on, synth_on, synth_rx_sel, tx_chain_on, pa_ramp;
logic rx_chain_on, gain_hold, mod_byte_valid, link_clk, demod_byte_valid;
logic demod_preamble, demod_header, demod_end, demod_crc_bad;
logic [23:0] carrier_word;
logic [15:0] if_word, got = 0;
int failures = 0, n_tests = 0, cyc = 0;
// address, write data, expected read back
logic [22:0] rows [8] = '{{7'h06, 8'hD9, 8'hD9}, {7'h07, 8'h06, 8'h06},
    {7'h08, 8'h8B, 8'h8B}, {7'h2F, 8'h0A, 8'h0A}, {7'h30, 8'hB0, 8'hB0},
    {7'h22, 8'h02, 8'h02}, {7'h0E, 8'h80, 8'h80}, {7'h7F, 8'h5A, 8'h00}};
////////////////////////////////////////////////////////////////////////
// short counts keep the run brief
modem_sequencer #(.SYM_CYCLES(20), .RAMP_CYCLES(4)) DUT(
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_clk(link_clk), .demod_byte(demod_byte),
    .demod_byte_valid(demod_byte_valid), .demod_preamble(demod_preamble),
    .demod_header(demod_header), .demod_end(demod_end),
    .demod_crc_bad(demod_crc_bad), .xosc_on(xosc_on),
    .baseband_on(baseband_on), .synth_on(synth_on),
    .synth_rx_sel(synth_rx_sel), .carrier_word(carrier_word),
    .if_word(if_word), .tx_chain_on(tx_chain_on), .pa_ramp(pa_ramp),
    .rx_chain_on(rx_chain_on), .gain_hold(gain_hold),
    .mod_byte(mod_byte), .mod_byte_valid(mod_byte_valid));
demod_model u_lnk(.run(run), .send(send), .bad(bad), .link_clk(link_clk),
    .demod_byte(demod_byte), .demod_byte_valid(demod_byte_valid),
    .demod_preamble(demod_preamble), .demod_header(demod_header),
    .demod_end(demod_end), .demod_crc_bad(demod_crc_bad));
////////////////////////////////////////////////////////////////////////
always #5 clk_sys = ~clk_sys;
// one capture per link period: valid stays high across back-to-back bytes
always @(negedge link_clk)
    if (mod_byte_valid) got <= {got[7:0], mod_byte};
task automatic close_out;
    if (failures == 0 && n_tests > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
always @(posedge clk_sys)
begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
        failures++;
        close_out;
    end
end
// an idle cycle after each strobe so no signal is driven twice at once
task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
endtask
task automatic crd(input logic [6:0] a, input logic [7:0] e, input bit c);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // read data appear in the cycle after the strobe and hold until the next read
    #1 v = reg_rdata;
    if (c)
        `CHK(v, e)
    @(posedge clk_sys);
endtask
task automatic poll(input int b);
    v = 0;
    for (int i = 0; i < 900 && !v[b]; i++)
        crd(7'h12, 8'h00, 0);
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1 `CHK(carrier_word, 24'h6C8000)
    wr(7'h01, 8'h03);
    #1 `CHK(tx_chain_on, 1'b0)
    wr(7'h01, 8'h80);
    wr(7'h0D, 8'h80);
    wr(7'h00, 8'h55);
    crd(7'h0D, 8'h80, 1);
    crd(7'h00, 8'h00, 1);
    foreach (rows[i])
    begin
        wr(rows[i][22:16], rows[i][15:8]);
        crd(rows[i][22:16], rows[i][7:0], 1);
    end
    #1 `CHK(carrier_word, 24'hD9068B)
    wr(7'h01, 8'h81);
    #1 `CHK(xosc_on & baseband_on, 1'b1)
    wr(7'h01, 8'h01);
    crd(7'h01, 8'h81, 1);
    wr(7'h01, 8'h84);
    #1 `CHK({synth_on, synth_rx_sel, if_word}, 18'h30000)
    wr(7'h01, 8'h82);
    #1 `CHK({synth_on, synth_rx_sel}, 2'b10)
    wr(7'h01, 8'h81);
    wr(7'h0D, 8'h80);
    wr(7'h00, 8'h11);
    wr(7'h00, 8'h22);
    crd(7'h0D, 8'h82, 1);
    wr(7'h0D, 8'h80);
    crd(7'h00, 8'h11, 1);
    crd(7'h00, 8'h22, 1);
    run <= 1'b1;
    wr(7'h01, 8'h83);
    poll(3);
    `CHK(v, 8'h08)
    `CHK(got, 16'h1122)
    crd(7'h01, 8'h81, 1);
    wr(7'h12, 8'hFF);
    wr(7'h01, 8'h86);
    send <= 1'b1;
    poll(6);
    `CHK(v, 8'h50)
    crd(7'h13, 8'h03, 1);
    crd(7'h14, 8'h03, 1);
    crd(7'h01, 8'h81, 1);
    wr(7'h0D, 8'h00);
    for (int i = 3; i < 6; i++)
        crd(7'h00, 8'hA0 + 8'(i), 1);
    send <= 1'b0;
    bad <= 1'b1;
    wr(7'h12, 8'hFF);
    wr(7'h0E, 8'h02);
    wr(7'h31, 8'h01);
    wr(7'h01, 8'h85);
    send <= 1'b1;
    poll(6);
    `CHK(v, 8'h70)
    crd(7'h14, 8'h02, 1);
    crd(7'h13, 8'h02, 1);
    crd(7'h01, 8'h85, 1);
    #1 `CHK(if_word, 16'h0AB0)
    `CHK(rx_chain_on, 1'b1)
    wr(7'h01, 8'h81);
    send <= 1'b0;
    wr(7'h12, 8'hFF);
    wr(7'h0D, 8'h00);
    wr(7'h1F, 8'h02);
    wr(7'h01, 8'h86);
    poll(7);
    `CHK(v, 8'h80)
    crd(7'h01, 8'h81, 1);
    // reset in mid-run: configuration and mode fall back to their defaults
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK({xosc_on, carrier_word}, 25'h06C8000)
    rstn <= 1'b1;
    @(posedge clk_sys);
    crd(7'h01, 8'h00, 1);
    close_out;
end
endmodule // radio_modem_mode_sequencer_tb_top
`default_nettype wire
